/* File: psq_pkg.sv */
package psq_pkg;

   // time base
   localparam int CLK_PERIOD_NS    = 10;
   localparam int NS_PER_US        = 1000;
   localparam int NS_PER_MS        = 1000000;
   localparam int REFRESH_TIME_US  = 400;
   localparam int SHUTDOWN_WAIT_MS = 120;
   localparam int MS_CYCLES_DFLT   = NS_PER_MS / CLK_PERIOD_NS;
   localparam int REFRESH_CYC_DFLT = REFRESH_TIME_US * NS_PER_US
                                     / CLK_PERIOD_NS;

   // timers and configuration layout
   localparam int NUM_FLAGS   = 3;
   localparam int NUM_DELAYS  = 6;
   localparam int NUM_TIMERS  = 7;
   localparam int HOLD_TIMER  = 6;
   localparam int TIMER_W     = 32;
   localparam int MS_W        = 8;
   localparam int IDX_W       = 4;
   localparam int SET_W       = 2;
   localparam int ORDER_W     = 3;
   localparam int FLAG_IDX_W  = 2;
   localparam int STATE_W     = 9;
   localparam logic [MS_W-1:0] STEP_UNIT_MS = 8'h02;

   // register map, byte addresses
   localparam logic [31:0] REG_CTRL_ADDR   = 32'h0000_0000;
   localparam logic [31:0] REG_DELAY_ADDR  = 32'h0000_0004;
   localparam logic [31:0] REG_STATUS_ADDR = 32'h0000_0008;

   // field positions
   localparam int CTRL_SET_LSB   = 0;
   localparam int CTRL_ORDER_LSB = 2;
   localparam int ST_REL_LSB     = 0;
   localparam int ST_PIN_LSB     = 4;
   localparam int ST_TRIG_BIT    = 8;
   localparam int ST_ABORT_BIT   = 9;
   localparam int ST_STATE_LSB   = 16;

   // reset values
   localparam logic [SET_W-1:0]   CTRL_SET_RST   = 2'h0;
   localparam logic [ORDER_W-1:0] CTRL_ORDER_RST = 3'h1;
   localparam logic [NUM_DELAYS*IDX_W-1:0] DELAY_RST = 24'hff_ffff;

   // ahb-lite
   localparam int          HTRANS_ACTIVE_BIT = 1;
   localparam logic        HRESP_OKAY        = 1'b0;

   typedef enum logic [STATE_W-1:0]
   {
      ST_OFF  = 9'h001,
      ST_UP1  = 9'h002,
      ST_UP2  = 9'h004,
      ST_UP3  = 9'h008,
      ST_ON   = 9'h010,
      ST_HOLD = 9'h020,
      ST_DN1  = 9'h040,
      ST_DN2  = 9'h080,
      ST_DN3  = 9'h100
   } psq_state_t;

endpackage

/* File: psq_cfg_if.sv */
`timescale 1ns/1ns
interface psq_cfg_if;
   import psq_pkg::*;

   logic [SET_W-1:0]            opt_set;
   logic [NUM_DELAYS*IDX_W-1:0] delay_idx;
   logic [ORDER_W-1:0]          order_sel;
   logic [NUM_FLAGS-1:0]        released;
   logic [NUM_FLAGS-1:0]        pin_level;
   logic                        trigger;
   logic                        aborted;
   logic [STATE_W-1:0]          state;

   modport regs
   (
      output opt_set, delay_idx, order_sel,
      input  released, pin_level, trigger, aborted, state
   );

   modport core
   (
      input  opt_set, delay_idx, order_sel,
      output released, pin_level, trigger, aborted, state
   );
endinterface

/* File: psq_timer.sv */
`timescale 1ns/1ns
module psq_timer
   import psq_pkg::*;
#(
   parameter int W = TIMER_W
)
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         run,
   input  wire logic [W-1:0] target,
   output      logic         done
);

   typedef struct packed
   {
      logic [W-1:0] count;
   } psq_timer_t;

   psq_timer_t s;
   psq_timer_t next_s;

   // count restarts whenever run drops, so a glitch leaves no residue
   always_comb
   begin
      next_s = s;
      if (!run)
      begin
         next_s.count = '0;
      end
      else if (s.count < target)
      begin
         next_s.count = s.count + W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign done = run && (s.count >= target);

endmodule

/* File: psq_ahb_regs.sv */
`timescale 1ns/1ns
module psq_ahb_regs
   import psq_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   psq_cfg_if.regs          cfg
);

   typedef struct packed
   {
      logic                        wr_pend;
      logic [31:0]                 wr_addr;
      logic [SET_W-1:0]            opt_set;
      logic [ORDER_W-1:0]          order_sel;
      logic [NUM_DELAYS*IDX_W-1:0] delay_idx;
      logic [31:0]                 rdata;
   } psq_regs_t;

   psq_regs_t   s;
   psq_regs_t   next_s;
   logic        take;
   logic [31:0] status;

   assign take = hsel && hready && htrans[HTRANS_ACTIVE_BIT];

   always_comb
   begin
      status = '0;
      status[ST_REL_LSB +: NUM_FLAGS]   = cfg.released;
      status[ST_PIN_LSB +: NUM_FLAGS]   = cfg.pin_level;
      status[ST_TRIG_BIT]               = cfg.trigger;
      status[ST_ABORT_BIT]              = cfg.aborted;
      status[ST_STATE_LSB +: STATE_W]   = cfg.state;
   end

   always_comb
   begin
      next_s = s;
      next_s.wr_pend = 1'b0;
      // write lands in its data phase, before a following read samples
      if (s.wr_pend)
      begin
         if (s.wr_addr == REG_CTRL_ADDR)
         begin
            next_s.opt_set   = hwdata[CTRL_SET_LSB +: SET_W];
            next_s.order_sel = hwdata[CTRL_ORDER_LSB +: ORDER_W];
         end
         else if (s.wr_addr == REG_DELAY_ADDR)
         begin
            next_s.delay_idx = hwdata[NUM_DELAYS*IDX_W-1:0];
         end
      end
      if (take)
      begin
         next_s.wr_pend = hwrite;
         next_s.wr_addr = haddr;
         // a write leaves the last read data standing
         if (!hwrite)
         begin
            next_s.rdata = '0;
            if (haddr == REG_CTRL_ADDR)
            begin
               next_s.rdata[CTRL_SET_LSB +: SET_W]     = next_s.opt_set;
               next_s.rdata[CTRL_ORDER_LSB +: ORDER_W] = next_s.order_sel;
            end
            else if (haddr == REG_DELAY_ADDR)
            begin
               next_s.rdata[NUM_DELAYS*IDX_W-1:0] = next_s.delay_idx;
            end
            else if (haddr == REG_STATUS_ADDR)
            begin
               next_s.rdata = status;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s.wr_pend   <= 1'b0;
         s.wr_addr   <= '0;
         s.opt_set   <= CTRL_SET_RST;
         s.order_sel <= CTRL_ORDER_RST;
         s.delay_idx <= DELAY_RST;
         s.rdata     <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // hsize unused: only whole-word transfers reach this slave
   assign hrdata        = s.rdata;
   assign hreadyout     = 1'b1;
   assign hresp         = HRESP_OKAY;
   assign cfg.opt_set   = s.opt_set;
   assign cfg.order_sel = s.order_sel;
   assign cfg.delay_idx = s.delay_idx;

endmodule

/* File: psq_sequencer.sv */
`timescale 1ns/1ns
module psq_sequencer
   import psq_pkg::*;
#(
   parameter int MS_CYCLES      = MS_CYCLES_DFLT,
   parameter int REFRESH_CYCLES = REFRESH_CYC_DFLT
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic [31:0] hrdata,
   output      logic        hreadyout,
   output      logic        hresp,
   input  wire logic        sequence_trigger_input,
   input  wire logic        rail_release_first_in,
   output      logic        rail_release_first_out,
   output      logic        rail_release_first_oe_n,
   input  wire logic        rail_release_second_in,
   output      logic        rail_release_second_out,
   output      logic        rail_release_second_oe_n,
   input  wire logic        rail_release_third_in,
   output      logic        rail_release_third_out,
   output      logic        rail_release_third_oe_n
);

   typedef struct packed
   {
      psq_state_t                  state;
      logic [NUM_FLAGS-1:0]        released;
      logic                        aborted;
      logic                        trig_q;
      logic [SET_W-1:0]            opt_set;
      logic [NUM_DELAYS*IDX_W-1:0] delay_idx;
      logic [ORDER_W-1:0]          order_sel;
   } psq_core_t;

   psq_core_t                     s;
   psq_core_t                     next_s;
   logic [NUM_TIMERS-1:0]         run;
   logic [NUM_TIMERS-1:0]         done;
   logic [TIMER_W-1:0]            target [NUM_TIMERS];
   logic [MS_W-1:0]               step_ms;
   logic                          fall;
   logic [3*FLAG_IDX_W-1:0]       down_order;

   psq_cfg_if cfg_bus ();

   psq_ahb_regs u_regs
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .cfg       (cfg_bus.regs)
   );

   // order table
   // packed as {third, second, first} flag index to pull low
   function automatic logic [3*FLAG_IDX_W-1:0] order_of
   (
      input logic [ORDER_W-1:0] sel
   );
      logic [3*FLAG_IDX_W-1:0] ord;
      case (sel)
         3'h2:    ord = {2'h1, 2'h0, 2'h2};
         3'h3:    ord = {2'h0, 2'h2, 2'h1};
         3'h4:    ord = {2'h2, 2'h0, 2'h1};
         3'h5:    ord = {2'h1, 2'h2, 2'h0};
         3'h6:    ord = {2'h2, 2'h1, 2'h0};
         // unused codes fall back to the plain reverse order
         default: ord = {2'h0, 2'h1, 2'h2};
      endcase
      return ord;
   endfunction

   assign down_order = order_of(s.order_sel);

   // step of 2, 4, 6 or 8 ms
   assign step_ms = MS_W'({s.opt_set, 1'b0}) + STEP_UNIT_MS;

   assign fall = s.trig_q && !sequence_trigger_input;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DELAYS; gi++)
      begin : g_delay
         logic [MS_W-1:0]    ms_val;
         logic [TIMER_W-1:0] extra;
         assign ms_val = MS_W'(s.delay_idx[gi*IDX_W +: IDX_W] * step_ms);
         assign extra  = (gi == 0 || gi == 3) ?
                         TIMER_W'(REFRESH_CYCLES) : '0;
         assign target[gi] = TIMER_W'(ms_val * MS_CYCLES) + extra;
      end
   endgenerate

   assign target[HOLD_TIMER] = TIMER_W'(SHUTDOWN_WAIT_MS * MS_CYCLES);

   generate
      for (gi = 0; gi < NUM_TIMERS; gi++)
      begin : g_timer
         psq_timer #(.W(TIMER_W)) u_timer
         (
            .hclk    (hclk),
            .hresetn (hresetn),
            .run     (run[gi]),
            .target  (target[gi]),
            .done    (done[gi])
         );
      end
   endgenerate

   always_comb
   begin
      run = '0;
      // timer one runs only while high
      run[0] = (s.state == ST_UP1) && sequence_trigger_input;
      run[1] = (s.state == ST_UP2) && !fall;
      run[2] = (s.state == ST_UP3) && !fall;
      run[3] = (s.state == ST_DN1);
      run[4] = (s.state == ST_DN2);
      run[5] = (s.state == ST_DN3);
      run[HOLD_TIMER] = (s.state == ST_HOLD);
   end

   always_comb
   begin
      next_s = s;
      next_s.trig_q = sequence_trigger_input;
      case (s.state)
         ST_OFF:
         begin
            next_s.released = '0;
            next_s.aborted  = 1'b0;
            if (sequence_trigger_input)
            begin
               next_s.opt_set   = cfg_bus.opt_set;
               next_s.delay_idx = cfg_bus.delay_idx;
               next_s.order_sel = cfg_bus.order_sel;
               next_s.state     = ST_UP1;
            end
         end
         ST_UP1:
         begin
            if (!sequence_trigger_input)
            begin
               next_s.state = ST_OFF;
            end
            else if (done[0])
            begin
               next_s.released[0] = 1'b1;
               next_s.state       = ST_UP2;
            end
         end
         ST_UP2:
         begin
            if (!sequence_trigger_input)
            begin
               next_s.aborted = 1'b1;
            end
            if (done[1])
            begin
               next_s.released[1] = 1'b1;
               next_s.state       = ST_UP3;
            end
         end
         ST_UP3:
         begin
            if (!sequence_trigger_input)
            begin
               next_s.aborted = 1'b1;
            end
            if (done[2])
            begin
               next_s.released[2] = 1'b1;
               if (next_s.aborted)
               begin
                  next_s.state = ST_HOLD;
               end
               else
               begin
                  next_s.state = ST_ON;
               end
            end
         end
         ST_ON:
         begin
            if (!sequence_trigger_input)
            begin
               next_s.state = ST_DN1;
            end
         end
         ST_HOLD:
         begin
            if (done[HOLD_TIMER])
            begin
               next_s.state = ST_DN1;
            end
         end
         ST_DN1:
         begin
            if (done[3])
            begin
               next_s.released[down_order[0 +: FLAG_IDX_W]] = 1'b0;
               next_s.state = ST_DN2;
            end
         end
         ST_DN2:
         begin
            if (done[4])
            begin
               next_s.released[down_order[FLAG_IDX_W +: FLAG_IDX_W]] = 1'b0;
               next_s.state = ST_DN3;
            end
         end
         ST_DN3:
         begin
            if (done[5])
            begin
               next_s.released = '0;
               next_s.state    = ST_OFF;
            end
         end
         default:
         begin
            next_s.state    = ST_OFF;
            next_s.released = '0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s.state     <= ST_OFF;
         s.released  <= '0;
         s.aborted   <= 1'b0;
         s.trig_q    <= 1'b0;
         s.opt_set   <= CTRL_SET_RST;
         s.delay_idx <= DELAY_RST;
         s.order_sel <= CTRL_ORDER_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   // open drain: only ever drives low, enable low means pulling low
   assign rail_release_first_out   = 1'b0;
   assign rail_release_second_out  = 1'b0;
   assign rail_release_third_out   = 1'b0;
   assign rail_release_first_oe_n  = s.released[0];
   assign rail_release_second_oe_n = s.released[1];
   assign rail_release_third_oe_n  = s.released[2];

   assign cfg_bus.released  = s.released;
   assign cfg_bus.pin_level = {rail_release_third_in,
                               rail_release_second_in,
                               rail_release_first_in};
   assign cfg_bus.trigger   = sequence_trigger_input;
   assign cfg_bus.aborted   = s.aborted;
   assign cfg_bus.state     = s.state;

endmodule

/* File: psq_sequencer_asserts.sv */
`timescale 1ns/1ns
module psq_sequencer_asserts
   import psq_pkg::*;
#(
   parameter int MS_CYCLES      = 10,
   parameter int REFRESH_CYCLES = 4
)
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        sequence_trigger_input,
   input wire logic        rail_release_first_in,
   input wire logic        rail_release_first_out,
   input wire logic        rail_release_first_oe_n,
   input wire logic        rail_release_second_in,
   input wire logic        rail_release_second_out,
   input wire logic        rail_release_second_oe_n,
   input wire logic        rail_release_third_in,
   input wire logic        rail_release_third_out,
   input wire logic        rail_release_third_oe_n
);
   logic [2:0] oe_n;
   logic       rd_take;
   logic       full_seen;
   assign oe_n = {rail_release_third_oe_n, rail_release_second_oe_n,
                  rail_release_first_oe_n};
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   // a drop is only legal once every rail has been up
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         full_seen <= 1'b0;
      else if (oe_n == 3'h7)
         full_seen <= 1'b1;
      else if (oe_n == 3'h0)
         full_seen <= 1'b0;
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence s_bad_read;
      rd_take && (haddr > REG_STATUS_ADDR);
   endsequence
   sequence s_any_drop;
      $fell(oe_n[0]) || $fell(oe_n[1]) || $fell(oe_n[2]);
   endsequence
   a_reset_low: assert property (disable iff (1'b0)
      !hresetn |-> oe_n == 3'h0) else $error("flag released in reset");
   a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_pins_low: assert property (rail_release_first_out == 1'b0 &&
      rail_release_second_out == 1'b0 && rail_release_third_out == 1'b0)
      else $error("open-drain pin driven high");
   a_unmapped_zero: assert property (s_bad_read |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_second_order: assert property ($rose(oe_n[1]) |-> oe_n[0])
      else $error("second rail before first");
   a_third_order: assert property ($rose(oe_n[2]) |-> oe_n[1:0] == 2'h3)
      else $error("third rail before second");
   a_first_trig: assert property ($rose(oe_n[0]) |->
      $past(sequence_trigger_input) &&
      $past(sequence_trigger_input, REFRESH_CYCLES))
      else $error("first rail without held trigger");
   a_one_change: assert property ($countones(oe_n ^ $past(oe_n)) <= 1)
      else $error("two rails moved at once");
   a_drop_full: assert property (s_any_drop |-> full_seen)
      else $error("rail dropped before power-up ended");
endmodule

/* File: psq_rail_model.sv */
`timescale 1ns/1ns
module psq_rail_model
(
   input  wire logic [2:0] oe_n,
   input  wire logic [2:0] drv,
   output      logic [2:0] pin
);
   // regulator enable inputs carry pull-ups, so a released pin reads high
   // open-drain rails
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         pin[i] = oe_n[i] ? 1'b1 : drv[i];
   end
endmodule

/* File: psq_sequencer_tb.sv */
`timescale 1ns/1ns
module psq_sequencer_tb;
   import psq_pkg::*;
   localparam int MSC  = 10;
   localparam int RFC  = 4;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b1;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0000_0000;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h2;
   logic [31:0] hwdata  = 32'h0000_0000;
   logic        trig    = 1'b0;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   wire  [2:0]  oe_n;
   wire  [2:0]  outs;
   wire  [2:0]  pins;
   int          num_errors = 0;
   int          n_checks   = 0;
   int          cyc        = 0;
   int          st         = 0;
   // delay indices 1,2,1 up and 2,1,3 down
   int          uix [3] = '{1, 2, 1};
   int          dix [3] = '{2, 1, 3};
   int          ord [6][3] = '{'{2, 1, 0}, '{2, 0, 1}, '{1, 2, 0},
                               '{1, 0, 2}, '{0, 2, 1}, '{0, 1, 2}};
   psq_sequencer #(.MS_CYCLES(MSC), .REFRESH_CYCLES(RFC)) dut_u
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .sequence_trigger_input(trig),
      .rail_release_first_in(pins[0]), .rail_release_first_out(outs[0]),
      .rail_release_first_oe_n(oe_n[0]),
      .rail_release_second_in(pins[1]), .rail_release_second_out(outs[1]),
      .rail_release_second_oe_n(oe_n[1]),
      .rail_release_third_in(pins[2]), .rail_release_third_out(outs[2]),
      .rail_release_third_oe_n(oe_n[2])
   );
   psq_rail_model rail_u (.oe_n(oe_n), .drv(outs), .pin(pins));
   always #5 hclk = ~hclk;
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int exp, input int tol);
      n_checks++;
      if (got < exp - tol || got > exp + tol)
      begin
         num_errors++;
         $display("wrong value at %0t: %0d cycles not %0d", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      q = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk32(q, e);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   // edges until the given rail reaches v, seen at the edge before update
   task automatic wait_flag(input int f, input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (oe_n[f] !== v);
   endtask
   task automatic run_seq(input int s);
      int n;
      int e;
      // every option set gets used: step of 2, 4, 6 or 8 ms
      st = 2 * MSC * (s % 4 + 1);
      wr(REG_CTRL_ADDR, (32'(s) << 2) | 32'(s % 4));
      trig <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         wait_flag(i, 1'b1, n);
         e = (i == 0) ? 3 + RFC + uix[i] * st : 1 + uix[i] * st;
         chk_rng(n, e, 1);
      end
      rd(REG_STATUS_ADDR, 32'h0010_0177);
      trig <= 1'b0;
      for (int p = 0; p < 3; p++)
      begin
         wait_flag(ord[s - 1][p], 1'b0, n);
         e = (p == 0) ? 3 + RFC + dix[p] * st : 1 + dix[p] * st;
         chk_rng(n, e, 1);
      end
      rd(REG_STATUS_ADDR, 32'h0001_0000);
   endtask
   initial
   begin
      int n;
      int t0;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(REG_CTRL_ADDR, 32'h0000_0004);
      rd(REG_DELAY_ADDR, 32'h00ff_ffff);
      wr(REG_STATUS_ADDR, 32'hffff_ffff);
      wr(32'h0000_000c, 32'hffff_ffff);
      rd(32'h0000_000c, 32'h0000_0000);
      rd(REG_STATUS_ADDR, 32'h0001_0000);
      wr(REG_DELAY_ADDR, 32'h0031_2121);
      rd(REG_DELAY_ADDR, 32'h0031_2121);
      // trigger pulse shorter than the first delay is filtered
      trig <= 1'b1;
      repeat (10) @(posedge hclk);
      trig <= 1'b0;
      repeat (40) @(posedge hclk);
      rd(REG_STATUS_ADDR, 32'h0001_0000);
      for (int s = 1; s <= 6; s++)
         run_seq(s);
      // trigger falls in the second stage: finish, hold, power down
      trig <= 1'b1;
      wait_flag(0, 1'b1, n);
      repeat (3) @(posedge hclk);
      trig <= 1'b0;
      // the fall restarts the second timer from zero
      wait_flag(1, 1'b1, n);
      chk_rng(n, 3 + uix[1] * st, 1);
      wait_flag(2, 1'b1, n);
      t0 = cyc;
      rd(REG_STATUS_ADDR, 32'h0020_0277);
      wait_flag(0, 1'b0, n);
      n = SHUTDOWN_WAIT_MS * MSC + 3 + dix[0] * st + RFC;
      chk_rng(cyc - t0, n, 3);
      wait_flag(2, 1'b0, n);
      summarize();
   end
endmodule
bind psq_sequencer psq_sequencer_asserts
   #(.MS_CYCLES(MS_CYCLES), .REFRESH_CYCLES(REFRESH_CYCLES)) chk_u
(
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sequence_trigger_input(sequence_trigger_input),
   .rail_release_first_in(rail_release_first_in),
   .rail_release_first_out(rail_release_first_out),
   .rail_release_first_oe_n(rail_release_first_oe_n),
   .rail_release_second_in(rail_release_second_in),
   .rail_release_second_out(rail_release_second_out),
   .rail_release_second_oe_n(rail_release_second_oe_n),
   .rail_release_third_in(rail_release_third_in),
   .rail_release_third_out(rail_release_third_out),
   .rail_release_third_oe_n(rail_release_third_oe_n)
);
